// *** design/ddcmx_pkg.sv ***
// Package with register map, field positions and mode codes for the mixer control block
package ddcmx_pkg;
    localparam logic [11:0] test_enable_offset = 12'h327;
    localparam logic [11:0] ctrl_offset = 12'h330;
    localparam logic [11:0] pattern_select_offset = 12'h550;
    localparam logic [11:0] decim_select_offset = 12'h310;
    localparam logic [11:0] status_offset = 12'h400;
    localparam int test_i_bit = 0;
    localparam int test_q_bit = 2;
    localparam logic [7:0] test_enable_mask = 8'h05;
    localparam int mixer_select_bit = 7;
    localparam int gain_select_bit = 6;
    localparam int if_mode_lsb = 4;
    localparam int c2r_bit = 3;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] test_enable_reset = 8'h00;
    localparam logic [3:0] pattern_select_reset = 4'h0;
    localparam logic [2:0] decim_select_reset = 3'h0;
    localparam logic [2:0] decim_first_two_halfband = 3'h0;
    localparam logic [5:0] decim_two = 6'h02;
    localparam logic [5:0] decim_four = 6'h04;
    localparam logic [5:0] decim_unsupported = 6'h00;
    typedef enum logic [1:0] {
        ddcmx_if_variable,
        ddcmx_if_zero,
        ddcmx_if_fs,
        ddcmx_if_test
    } ddcmx_if_mode_e;
endpackage

// *** design/ddcmx_datapath.sv ***
// Sample path: test source select, mixing, gain and complex-to-real conversion
`timescale 1ns/1ps
module ddcmx_datapath #(
    parameter int width = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    input wire logic signed [width-1:0] in_i,
    input wire logic signed [width-1:0] in_q,
    input wire logic signed [width-1:0] test_a,
    input wire logic signed [width-1:0] test_b,
    input wire logic signed [width-1:0] nco_cos,
    input wire logic signed [width-1:0] nco_sin,
    input wire logic test_i_en,
    input wire logic test_q_en,
    input wire logic mixer_complex,
    input wire logic gain_double,
    input wire logic [1:0] if_mode,
    input wire logic c2r_en,
    output logic out_valid,
    output logic signed [width-1:0] out_i,
    output logic signed [width-1:0] out_q
);
    localparam int pw = 2 * width;
    wire logic signed [width-1:0] src_i;
    wire logic signed [width-1:0] src_q;
    wire logic signed [width-1:0] mix_q_in;
    wire logic signed [pw-1:0] prod_ic;
    wire logic signed [pw-1:0] prod_qs;
    wire logic signed [pw-1:0] prod_is;
    wire logic signed [pw-1:0] prod_qc;
    wire logic signed [width-1:0] var_i;
    wire logic signed [width-1:0] var_q;
    logic signed [width-1:0] mix_i;
    logic signed [width-1:0] mix_q;
    wire logic signed [width-1:0] gain_i;
    wire logic signed [width-1:0] gain_q;
    wire logic signed [width-1:0] fin_i;
    wire logic signed [width-1:0] fin_q;
    logic fs_phase;

    assign src_i = test_i_en ? test_a : in_i;
    assign src_q = test_q_en ? test_b : in_q;
    // A real mixer sees one channel, so Q follows I
    assign mix_q_in = mixer_complex ? src_q : src_i;
    assign prod_ic = src_i * nco_cos;
    assign prod_qs = mix_q_in * nco_sin;
    assign prod_is = src_i * nco_sin;
    assign prod_qc = mix_q_in * nco_cos;
    assign var_i = width'((prod_ic - prod_qs) >>> (width - 1));
    assign var_q = width'((prod_is + prod_qc) >>> (width - 1));

    always_comb begin
        unique case (ddcmx_pkg::ddcmx_if_mode_e'(if_mode))
            ddcmx_pkg::ddcmx_if_variable: begin
                mix_i = var_i;
                mix_q = var_q;
            end
            ddcmx_pkg::ddcmx_if_zero: begin
                mix_i = src_i;
                mix_q = mix_q_in;
            end
            ddcmx_pkg::ddcmx_if_fs: begin
                mix_i = fs_phase ? -src_i : src_i;
                mix_q = fs_phase ? -mix_q_in : mix_q_in;
            end
            ddcmx_pkg::ddcmx_if_test: begin
                mix_i = test_a;
                mix_q = test_b;
            end
        endcase
    end

    // Doubling wraps on overflow; headroom is the user's concern
    assign gain_i = gain_double ? (mix_i <<< 1) : mix_i;
    assign gain_q = gain_double ? (mix_q <<< 1) : mix_q;
    // Extra fs/4-style mix: alternate I and negated Q, real output only
    assign fin_i = c2r_en ? (fs_phase ? -gain_q : gain_i) : gain_i;
    assign fin_q = c2r_en ? '0 : gain_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fs_phase <= 1'b0;
            out_valid <= 1'b0;
            out_i <= '0;
            out_q <= '0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                fs_phase <= ~fs_phase;
                out_i <= fin_i;
                out_q <= fin_q;
            end
        end
    end
endmodule // ddcmx_datapath

// *** design/ddcmx_top.sv ***
// Mixer control block: AHB-Lite register slave and mixer sample path
`timescale 1ns/1ps
module ddcmx_top #(
    parameter int width = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic in_valid,
    input wire logic signed [width-1:0] in_i,
    input wire logic signed [width-1:0] in_q,
    input wire logic signed [width-1:0] test_a,
    input wire logic signed [width-1:0] test_b,
    input wire logic signed [width-1:0] nco_cos,
    input wire logic signed [width-1:0] nco_sin,
    output logic out_valid,
    output logic signed [width-1:0] out_i,
    output logic signed [width-1:0] out_q,
    output logic [3:0] pattern_select,
    output logic [5:0] decimation
);
    logic [7:0] ctrl;
    logic [7:0] test_enable;
    logic [2:0] decim_select;
    logic wr_pend;
    logic [11:0] wr_addr;
    wire logic addr_phase;
    wire logic [11:0] a_off;
    wire logic wr_ctrl;
    wire logic wr_test;
    wire logic wr_pat;
    wire logic wr_dec;
    wire logic [31:0] next_hrdata;
    wire logic [5:0] next_decimation;
    wire logic c2r;

    assign addr_phase = hsel & hready & htrans[1];
    assign a_off = haddr[11:0];
    assign wr_ctrl = wr_pend & (wr_addr == ddcmx_pkg::ctrl_offset);
    assign wr_test = wr_pend & (wr_addr == ddcmx_pkg::test_enable_offset);
    assign wr_pat = wr_pend & (wr_addr == ddcmx_pkg::pattern_select_offset);
    assign wr_dec = wr_pend & (wr_addr == ddcmx_pkg::decim_select_offset);
    assign c2r = ctrl[ddcmx_pkg::c2r_bit];

    // Unmapped addresses read zero; writes there are dropped
    assign next_hrdata =
        (a_off == ddcmx_pkg::ctrl_offset) ? {24'h000000, ctrl} :
        (a_off == ddcmx_pkg::test_enable_offset) ? {24'h000000, test_enable} :
        (a_off == ddcmx_pkg::pattern_select_offset) ? {28'h0000000, pattern_select} :
        (a_off == ddcmx_pkg::decim_select_offset) ? {29'h0, decim_select} :
        (a_off == ddcmx_pkg::status_offset) ? {26'h0, decimation} :
        32'h00000000;

    // Only code 000 is decoded here; others report zero
    assign next_decimation = (decim_select == ddcmx_pkg::decim_first_two_halfband) ?
        (c2r ? ddcmx_pkg::decim_two : ddcmx_pkg::decim_four) :
        ddcmx_pkg::decim_unsupported;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend <= addr_phase & hwrite;
            wr_addr <= a_off;
            if (addr_phase && !hwrite) begin
                hrdata <= next_hrdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= ddcmx_pkg::ctrl_reset;
            test_enable <= ddcmx_pkg::test_enable_reset;
            pattern_select <= ddcmx_pkg::pattern_select_reset;
            decim_select <= ddcmx_pkg::decim_select_reset;
            decimation <= ddcmx_pkg::decim_four;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            decimation <= next_decimation;
            if (wr_ctrl) begin
                ctrl <= hwdata[7:0];
            end
            if (wr_test) begin
                test_enable <= hwdata[7:0] & ddcmx_pkg::test_enable_mask;
            end
            if (wr_pat) begin
                pattern_select <= hwdata[3:0];
            end
            if (wr_dec) begin
                decim_select <= hwdata[2:0];
            end
        end
    end

    ddcmx_datapath #(
        .width(width)
    ) u_path (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(in_valid),
        .in_i(in_i),
        .in_q(in_q),
        .test_a(test_a),
        .test_b(test_b),
        .nco_cos(nco_cos),
        .nco_sin(nco_sin),
        .test_i_en(test_enable[ddcmx_pkg::test_i_bit]),
        .test_q_en(test_enable[ddcmx_pkg::test_q_bit]),
        .mixer_complex(ctrl[ddcmx_pkg::mixer_select_bit]),
        .gain_double(ctrl[ddcmx_pkg::gain_select_bit]),
        .if_mode(ctrl[ddcmx_pkg::if_mode_lsb +: 2]),
        .c2r_en(c2r),
        .out_valid(out_valid),
        .out_i(out_i),
        .out_q(out_q)
    );
endmodule // ddcmx_top

// *** tb/ddcmx_checker.sv ***
// Port-level assertions for the mixer control block
`timescale 1ns/1ps
module ddcmx_checker #(
    parameter int width = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic in_valid,
    input wire logic out_valid,
    input wire logic signed [width-1:0] out_i,
    input wire logic signed [width-1:0] out_q,
    input wire logic [3:0] pattern_select,
    input wire logic [5:0] decimation
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Four idle address phases let any pending write and its status update settle
    sequence quiet_bus;
        !(hsel && htrans[1]) [*4];
    endsequence
    sequence sample_in;
        in_valid;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout)
        else $error("wait state inserted");
    a_valid_follow: assert property (sample_in |=> out_valid)
        else $error("sample produced no output");
    a_valid_single: assert property (!in_valid |=> !out_valid)
        else $error("output without input sample");
    a_out_hold: assert property (!in_valid |=> $stable(out_i) && $stable(out_q))
        else $error("outputs moved without sample");
    a_decim_code: assert property (decimation inside {6'h00, 6'h02, 6'h04})
        else $error("decimation factor illegal");
    a_decim_quiet: assert property (quiet_bus |-> $stable(decimation))
        else $error("decimation moved without write");
    a_pattern_quiet: assert property (quiet_bus |-> $stable(pattern_select))
        else $error("pattern select moved without write");
endmodule // ddcmx_checker

bind ddcmx_top ddcmx_checker #(.width(width)) ddcmx_checker_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hreadyout(hreadyout), .hresp(hresp),
    .in_valid(in_valid), .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
    .pattern_select(pattern_select), .decimation(decimation));

// *** tb/ddcmx_top_tb.sv ***
// Self-checking bench for the mixer control block
`timescale 1ns/1ps
module ddcmx_top_tb;
    localparam logic [11:0] ctl = ddcmx_pkg::ctrl_offset;
    localparam logic [11:0] ten = ddcmx_pkg::test_enable_offset;
    localparam logic [11:0] pat = ddcmx_pkg::pattern_select_offset;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, in_valid = 0;
    logic hreadyout, hresp, out_valid;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic signed [15:0] in_i = 16'h0, in_q = 16'h0, out_i, out_q;
    logic signed [15:0] ta = 16'h0123, tb = 16'h0456;
    logic signed [15:0] nco_c = 16'h4000, nco_s = 16'h4000;
    logic [3:0] pattern_select;
    logic [5:0] decimation;
    int error_cnt = 0, n_tests = 0, nsamp = 0;
    always #25 hclk = ~hclk;
    ddcmx_top #(.width(16)) ddcmx_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .test_a(ta), .test_b(tb),
        .nco_cos(nco_c), .nco_sin(nco_s), .out_valid(out_valid), .out_i(out_i),
        .out_q(out_q), .pattern_select(pattern_select), .decimation(decimation));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; returns just after the data phase edge
    task bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(r, e);
    endtask
    task smp(input logic signed [15:0] i, q, ei, eq);
        in_valid <= 1'b1;
        in_i <= i;
        in_q <= q;
        @(posedge hclk);
        in_valid <= 1'b0;
        #1;
        chk(out_valid, 1'b1);
        chk(out_i, ei);
        chk(out_q, eq);
        nsamp++;
        @(posedge hclk);
    endtask
    task t_reset;
        rd(ctl, 32'h0);
        rd(ten, 32'h0);
        rd(pat, 32'h0);
        rd(ddcmx_pkg::status_offset, 32'h4);
        rd(12'h7fc, 32'h0);
        chk(decimation, 6'h04);
    endtask
    task t_test_src;
        wr(ten, 32'hff);
        rd(ten, 32'h05);
        wr(pat, 32'ha);
        wr(ctl, 32'h90);
        chk(pattern_select, 4'ha);
        smp(100, 200, ta, tb);
        wr(ten, 32'h01);
        smp(100, 200, ta, 200);
        wr(ten, 32'h00);
    endtask
    task t_modes;
        smp(100, -50, 100, -50);
        wr(ctl, 32'hd0);
        smp(100, -50, 200, -100);
        wr(ctl, 32'h10);
        smp(100, -50, 100, 100);
        wr(ctl, 32'hb0);
        smp(7, 9, ta, tb);
        // Sign of the sample-rate mix follows the running sample parity
        wr(ctl, 32'ha0);
        repeat (2) smp(30, -40, nsamp[0] ? -30 : 30, nsamp[0] ? 40 : -40);
    endtask
    task t_real_out;
        wr(ctl, 32'h98);
        rd(ctl, 32'h98);
        repeat (2) smp(30, -40, nsamp[0] ? 40 : 30, 0);
        chk(decimation, 6'h02);
        wr(ctl, 32'h00);
        rd(ctl, 32'h00);
        chk(decimation, 6'h04);
    endtask
    // Half-scale NCO words keep the expected products exact
    task t_variable;
        wr(ctl, 32'h80);
        smp(100, -50, 75, 25);
        nco_s <= 16'hc000;
        smp(100, -50, 25, -75);
    endtask
    task t_mid_reset;
        wr(ctl, 32'h48);
        wr(ten, 32'h04);
        wr(pat, 32'h3);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ctl, 32'h0);
        rd(ten, 32'h0);
        rd(pat, 32'h0);
        chk(decimation, 6'h04);
    endtask
    task wrap_up;
        $display("Checks %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_test_src();
        t_modes();
        t_real_out();
        t_variable();
        t_mid_reset();
        wrap_up();
    end
endmodule // ddcmx_top_tb
